// ===== design/abm_pkg.sv
package abm_pkg;

  // ***************************************************************
  // Bus constants
  // ***************************************************************
  localparam int ADDR_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int NARROW_SMALL_BITS = 20;
  localparam int NARROW_LARGE_BITS = 22;
  localparam logic [2:0] SPACE_CPU = 3'h7;
  localparam logic [2:0] SPACE_USER_DATA = 3'h1;
  localparam logic [23:0] ADDR_ALL_HIGH = 24'hff_ffff;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // ***************************************************************
  // Types
  // ***************************************************************
  // Kind of cycle requested by the core
  typedef enum logic [1:0] {
    ABM_CYC_READ = 2'b00,
    ABM_CYC_WRITE = 2'b01,
    ABM_CYC_INTACK = 2'b10,
    ABM_CYC_BREAK = 2'b11
  } abm_cyc_t;

  // Request from the core side
  typedef struct packed {
    abm_cyc_t kind;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [1:0] lanes;
    logic [2:0] space;
    logic [2:0] level;
  } abm_req_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ABM_IDLE = 2'b00,
    ABM_ADDR = 2'b01,
    ABM_WAIT = 2'b10,
    ABM_DONE = 2'b11
  } abm_state_t;

endpackage : abm_pkg

// ===== design/abm_lane_mux.sv
`timescale 1ns/1ps
// ***************************************************************
// Lane steering for write data and strobes
// ***************************************************************
module abm_lane_mux (
  // Request
  input wire abm_pkg::abm_req_t req,
  input wire logic eightBit,
  // Steered results
  output logic [15:0] laneData,
  output logic upperSel,
  output logic lowerSel
);
  import abm_pkg::*;

  // Combine lanes into bus values
  always_comb begin
    laneData = req.wdata;
    upperSel = req.lanes[1];
    lowerSel = req.lanes[0];
    if (eightBit) begin
      // Only low lane in narrow mode
      upperSel = 1'b0;
      lowerSel = 1'b1;
      laneData = {req.wdata[7:0], req.wdata[7:0]};
    end else if (req.lanes == 2'b01) begin
      // Byte copy; future parts may drop it
      laneData = {req.wdata[7:0], req.wdata[7:0]};
    end else if (req.lanes == 2'b10) begin
      laneData = {req.wdata[15:8], req.wdata[15:8]};
    end
  end

endmodule : abm_lane_mux

// ===== design/abm_bus_master.sv
`timescale 1ns/1ps
// ***************************************************************
// Asynchronous bus master sequencer
// ***************************************************************
module abm_bus_master #(
  parameter int ADDR_W = abm_pkg::ADDR_BITS,
  parameter bit NARROW = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core request side
  input wire logic reqValid,
  input wire abm_pkg::abm_req_t req,
  input wire logic eightBit,
  output logic reqBusy,
  output logic rspValid,
  output logic [15:0] rspData,
  // Bus pins
  output logic [23:0] word_address_lines,
  output logic addrOe,
  output logic address_strobe_n,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic readNotWrite,
  output logic ctrlOe,
  output logic [2:0] access_space_code,
  output logic [15:0] dataOut,
  output logic dataOe,
  input wire logic [15:0] dataIn,
  input wire logic transfer_ack_n
);
  import abm_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  abm_state_t state, next_state; // Sequencer state
  abm_req_t held, next_held; // Captured request
  logic [15:0] laneData; // Steered write data
  logic upperSel; // Upper lane wanted
  logic lowerSel; // Lower lane wanted
  logic [23:0] next_addrOut; // Address to drive
  logic next_addrOe; // Address driver enable
  logic next_as; // Address strobe, active low
  logic next_uds; // Upper byte strobe, active low
  logic next_lds; // Lower byte strobe, active low
  logic next_rw; // High for read
  logic next_ctrlOe; // Control driver enable
  logic next_dataOe; // Data driver enable
  logic next_rspValid; // Cycle end pulse
  logic next_busy; // Sequencer occupied
  logic [2:0] next_space; // Access space code
  logic [15:0] next_dataOut; // Write data to drive
  logic [15:0] next_rspData; // Latched read data

  // ***************************************************************
  // Lane steering
  // ***************************************************************
  // Lane steering helper
  abm_lane_mux u_lane (
    .req(held),
    .eightBit(eightBit),
    .laneData(laneData),
    .upperSel(upperSel),
    .lowerSel(lowerSel)
  );

  // ***************************************************************
  // Address helpers
  // ***************************************************************
  // Interrupt acknowledge decode, needed in several places
  function automatic logic is_ack_cycle(input abm_cyc_t k);
    return (k == ABM_CYC_INTACK);
  endfunction : is_ack_cycle

  // Mask address to the variant width
  // Lines above the variant width read as zero
  function automatic logic [23:0] width_mask(input logic [23:0] a);
    logic [23:0] m;
    m = ADDR_ALL_HIGH >> (ADDR_BITS - ADDR_W);
    return a & m;
  endfunction : width_mask

  // Address content for a given cycle
  function automatic logic [23:0] cycle_addr(input abm_req_t r, input logic eb);
    logic [23:0] a;
    // Breakpoint cycles keep the request address except A0 in 16-bit mode
    a = r.addr;
    if (is_ack_cycle(r.kind)) begin
      // Level on A3..A1, everything else high
      a = {ADDR_ALL_HIGH[23:4], r.level, 1'b1};
    end else if (!eb && !NARROW) begin
      // A0 held high in 16-bit mode
      a[0] = 1'b1;
    end
    return width_mask(a);
  endfunction : cycle_addr

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  // Defaults hold every pin; the response pulse drops on its own
  always_comb begin
    next_state = state;
    next_held = held;
    next_addrOut = word_address_lines;
    next_addrOe = addrOe;
    next_as = address_strobe_n;
    next_uds = upper_byte_strobe_n;
    next_lds = lower_byte_strobe_n;
    next_rw = readNotWrite;
    next_ctrlOe = ctrlOe;
    next_space = access_space_code;
    next_dataOut = dataOut;
    next_dataOe = dataOe;
    next_rspValid = 1'b0;
    next_rspData = rspData;
    next_busy = reqBusy;
    case (state)
      ABM_IDLE: begin
        // Bus released, strobes negated
        // Request taken only here; others wait unseen
        if (reqValid) begin
          next_held = req;
          next_addrOut = cycle_addr(req, eightBit);
          next_addrOe = 1'b1;
          next_ctrlOe = 1'b1;
          next_rw = (req.kind != ABM_CYC_WRITE);
          next_space = is_ack_cycle(req.kind) ? SPACE_CPU : req.space;
          next_busy = 1'b1;
          next_state = ABM_ADDR;
        end
      end
      ABM_ADDR: begin
        // Address stable one cycle before strobe
        next_as = 1'b0;
        next_uds = ~upperSel;
        next_lds = ~lowerSel;
        if (is_ack_cycle(held.kind)) begin
          // Vector lives on low byte
          next_uds = 1'b1;
          next_lds = 1'b0;
        end
        if (held.kind == ABM_CYC_WRITE) begin
          next_dataOut = laneData;
          next_dataOe = 1'b1;
        end
        next_state = ABM_WAIT;
      end
      ABM_WAIT: begin
        // Waits inserted until acknowledge seen
        // No timeout: a silent responder holds the bus
        if (!transfer_ack_n) begin
          if (readNotWrite) begin
            // Narrow mode ignores upper lines
            next_rspData = eightBit ? {8'h00, dataIn[7:0]} : dataIn;
          end
          next_as = 1'b1;
          next_uds = 1'b1;
          next_lds = 1'b1;
          next_rspValid = 1'b1;
          next_state = ABM_DONE;
        end
      end
      ABM_DONE: begin
        // Release lines after strobes negate
        // One cycle of overlap keeps address valid past strobes
        next_addrOe = 1'b0;
        next_ctrlOe = 1'b0;
        next_dataOe = 1'b0;
        next_rw = 1'b1;
        next_busy = 1'b0;
        next_state = ABM_IDLE;
      end
      default: begin
        // Unused code falls back to idle
        next_state = ABM_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Bus idle: strobes negated, drivers off
      state <= ABM_IDLE;
      held <= '0;
      word_address_lines <= ADDR_ALL_HIGH;
      addrOe <= 1'b0;
      address_strobe_n <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      readNotWrite <= 1'b1;
      ctrlOe <= 1'b0;
      access_space_code <= SPACE_USER_DATA;
      dataOut <= DATA_ZERO;
      dataOe <= 1'b0;
      rspValid <= 1'b0;
      rspData <= DATA_ZERO;
      reqBusy <= 1'b0;
    end else begin
      // Register the next values
      state <= next_state;
      held <= next_held;
      word_address_lines <= next_addrOut;
      addrOe <= next_addrOe;
      address_strobe_n <= next_as;
      upper_byte_strobe_n <= next_uds;
      lower_byte_strobe_n <= next_lds;
      readNotWrite <= next_rw;
      ctrlOe <= next_ctrlOe;
      access_space_code <= next_space;
      dataOut <= next_dataOut;
      dataOe <= next_dataOe;
      rspValid <= next_rspValid;
      rspData <= next_rspData;
      reqBusy <= next_busy;
    end
  end

endmodule : abm_bus_master

// ===== testbench/abm_asserts.sv
`timescale 1ns/1ps
module abm_asserts (
  // Clock, reset and mode
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic eightBit,
  input wire logic rspValid,
  // Bus pins
  input wire logic [23:0] word_address_lines,
  input wire logic addrOe,
  input wire logic address_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic readNotWrite,
  input wire logic ctrlOe,
  input wire logic [2:0] access_space_code,
  input wire logic [15:0] dataOut,
  input wire logic dataOe,
  input wire logic transfer_ack_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Address strobe asserted
  wire asOn = !address_strobe_n;
  strobe_valid_a: assert property (asOn |-> addrOe && ctrlOe)
    else $error("strobe without address");
  wait_hold_a: assert property (asOn && transfer_ack_n |=> asOn && $stable(word_address_lines))
    else $error("cycle dropped before ack");
  ack_end_a: assert property (asOn && !transfer_ack_n |=> !asOn && rspValid)
    else $error("ack did not end cycle");
  write_dir_a: assert property (dataOe |-> !readNotWrite)
    else $error("data driven on read");
  byte_copy_a: assert property (dataOe && upper_byte_strobe_n && !lower_byte_strobe_n
    |-> dataOut[15:8] == dataOut[7:0]) else $error("byte not copied");
  narrow_upper_a: assert property (eightBit && asOn |-> upper_byte_strobe_n)
    else $error("upper strobe in narrow mode");
  // Acknowledge is the CPU space cycle with only the lower strobe; breakpoints differ
  intack_addr_a: assert property (asOn && access_space_code == 3'h7
    && upper_byte_strobe_n && !eightBit
    |-> &word_address_lines[23:4] && word_address_lines[0]) else $error("bad ack address");
  a0_high_a: assert property (addrOe && !eightBit |-> word_address_lines[0])
    else $error("A0 low in wide mode");
  space_stable_a: assert property (asOn && $past(asOn) |-> $stable(access_space_code))
    else $error("space code moved");
  rsp_pulse_a: assert property (rspValid |=> !rspValid)
    else $error("response too long");
  cover property (asOn && !transfer_ack_n && !readNotWrite);
  cover property (asOn && access_space_code == 3'h7);
  cover property (eightBit && asOn);
endmodule : abm_asserts
bind abm_bus_master abm_asserts chk (.*);

// ===== testbench/abm_mem_model.sv
`timescale 1ns/1ps
// Memory with set wait count; vector on low byte in CPU space
module abm_mem_model (
  input wire logic clk,
  input wire logic [23:0] word_address_lines,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic readNotWrite,
  input wire logic [2:0] access_space_code,
  input wire logic [15:0] dataOut,
  input wire logic [3:0] waits,
  output logic [15:0] dataIn,
  output logic transfer_ack_n
);
  logic [15:0] mem [16];
  logic [3:0] cnt = 4'h0;
  wire [3:0] w = word_address_lines[4:1];
  initial transfer_ack_n = 1'b1;
  initial dataIn = 16'h0000;
  // Released bus toggles so stale data never looks valid
  always @(posedge clk) begin
    if (upper_byte_strobe_n && lower_byte_strobe_n) begin
      transfer_ack_n <= 1'b1;
      cnt <= 4'h0;
      dataIn <= ~dataIn;
    end else if (cnt < waits) begin
      cnt <= cnt + 4'h1;
    end else if (transfer_ack_n) begin
      transfer_ack_n <= 1'b0;
      if (access_space_code == 3'h7) begin
        dataIn <= {~dataIn[15:8], 5'h08, word_address_lines[3:1]};
      end else if (readNotWrite) begin
        dataIn <= mem[w];
      end else begin
        if (!upper_byte_strobe_n) mem[w][15:8] <= dataOut[15:8];
        if (!lower_byte_strobe_n) mem[w][7:0] <= dataOut[7:0];
      end
    end
  end
endmodule : abm_mem_model

// ===== testbench/abm_bus_master_tb.sv
`timescale 1ns/1ps
module abm_bus_master_tb;
  import abm_pkg::*;
  // Core side and far side signals
  logic clk = 0, sys_rst = 1, reqValid = 0, eightBit = 0;
  abm_req_t req = '0;
  logic [3:0] waits = 4'h0;
  logic reqBusy, rspValid, addrOe, address_strobe_n, upper_byte_strobe_n;
  logic lower_byte_strobe_n, readNotWrite, ctrlOe, dataOe, transfer_ack_n;
  logic [15:0] rspData, dataOut, dataIn;
  logic [23:0] word_address_lines;
  logic [2:0] access_space_code;
  int errors = 0, num_checks = 0;
  always #4 clk = ~clk;
  abm_bus_master uut (.*);
  abm_mem_model mem (.*);
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  // Reset held ten cycles, mode settles with it
  task automatic rst(input logic mode);
    sys_rst = 1;
    eightBit = mode;
    repeat (10) @(negedge clk);
    sys_rst = 0;
  endtask : rst
  // One bus cycle, bounded wait for the response pulse
  task automatic cyc(input abm_cyc_t k, input logic [23:0] a, input logic [15:0] d,
      input logic [1:0] ln, input logic [2:0] sp);
    int n;
    n = 0;
    req = '{kind: k, addr: a, wdata: d, lanes: ln, space: sp, level: a[2:0]};
    reqValid = 1;
    @(negedge clk);
    reqValid = 0;
    check("busy", 16'h0001, {15'h0000, reqBusy});
    while (rspValid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 60) begin
        errors++;
        results();
      end
    end
    @(negedge clk);
    check("idle", 16'h0000, {15'h0000, reqBusy});
    check("released", 16'h0000, {14'h0000, addrOe, dataOe});
  endtask : cyc
  task automatic s_word;
    waits = 4'h3;
    cyc(ABM_CYC_WRITE, 24'h00_0010, 16'h1234, 2'b11, SPACE_USER_DATA);
    waits = 4'h0;
    cyc(ABM_CYC_READ, 24'h00_0010, 16'h0000, 2'b11, SPACE_USER_DATA);
    check("word", 16'h1234, rspData);
  endtask : s_word
  // Single lanes must leave the other half alone
  task automatic s_bytes;
    cyc(ABM_CYC_WRITE, 24'h00_0004, 16'h5555, 2'b11, SPACE_USER_DATA);
    cyc(ABM_CYC_WRITE, 24'h00_0004, 16'habab, 2'b01, SPACE_USER_DATA);
    cyc(ABM_CYC_READ, 24'h00_0004, 16'h0000, 2'b11, SPACE_USER_DATA);
    check("low lane", 16'h55ab, rspData);
    cyc(ABM_CYC_WRITE, 24'h00_0004, 16'hcdcd, 2'b10, SPACE_USER_DATA);
    cyc(ABM_CYC_READ, 24'h00_0004, 16'h0000, 2'b11, SPACE_USER_DATA);
    check("high lane", 16'hcdab, rspData);
  endtask : s_bytes
  task automatic s_intack;
    cyc(ABM_CYC_INTACK, 24'h00_0005, 16'h0000, 2'b01, SPACE_CPU);
    check("vector", 16'h0045, {8'h00, rspData[7:0]});
    check("ack addr", 16'hfffb, word_address_lines[15:0]);
    check("ack space", 16'h0007, {13'h0000, access_space_code});
    cyc(ABM_CYC_BREAK, 24'h00_0010, 16'h0000, 2'b11, SPACE_CPU);
    check("break addr", 16'h0011, word_address_lines[15:0]);
  endtask : s_intack
  // Narrow mode keeps low byte, upper zeroed
  task automatic s_eight;
    rst(1'b1);
    cyc(ABM_CYC_READ, 24'h00_0004, 16'h0000, 2'b01, SPACE_USER_DATA);
    check("narrow", 16'h00ab, rspData);
  endtask : s_eight
  initial begin
    rst(1'b0);
    s_word();
    s_bytes();
    s_intack();
    s_eight();
    results();
  end
endmodule : abm_bus_master_tb
